//--- rtl/acsp_pkg.sv
// Constants, opcodes and types of the serial command and ready port.
// Assumes a 20 MHz ref_clk; the serial clock is sampled, never used as a clock.
package acsp_pkg;

  // Result format
  localparam int ACSP_RESULT_W = 16;
  localparam logic [15:0] ACSP_POS_FULL = 16'h7FFF;
  localparam logic [15:0] ACSP_NEG_FULL = 16'h8000;

  // Opcodes matched on the upper seven bits, low bit is don't care
  localparam logic [6:0] ACSP_OP_POWER_UP = 7'h00;
  localparam logic [6:0] ACSP_OP_POWER_DOWN = 7'h01;
  localparam logic [6:0] ACSP_OP_RESYNC = 7'h02;
  localparam logic [6:0] ACSP_OP_SOFT_RESET = 7'h03;
  localparam logic [6:0] ACSP_OP_READ_ONCE = 7'h09;
  localparam logic [6:0] ACSP_OP_CONT_READ = 7'h0A;
  localparam logic [6:0] ACSP_OP_STOP_CONT = 7'h0B;
  // Opcodes matched on the upper nibble, low nibble is the start register
  localparam logic [3:0] ACSP_NIB_REG_READ = 4'h2;
  localparam logic [3:0] ACSP_NIB_REG_WRITE = 4'h4;
  // Full-byte opcodes
  localparam logic [7:0] ACSP_OP_SYS_OFFSET_CAL = 8'h60;
  localparam logic [7:0] ACSP_OP_SYS_GAIN_CAL = 8'h61;
  localparam logic [7:0] ACSP_OP_INT_OFFSET_CAL = 8'h62;
  localparam logic [7:0] ACSP_OP_IDLE_BYTE = 8'hFF;
  localparam logic [7:0] ACSP_OP_RESTRICTED = 8'hF1;

  // Timing
  localparam int ACSP_CLK_PERIOD_NS = 50;
  localparam int ACSP_READY_PULSE_NS = 200;
  localparam int ACSP_PULSE_CYC = (ACSP_READY_PULSE_NS + ACSP_CLK_PERIOD_NS - 1) / ACSP_CLK_PERIOD_NS;
  localparam int ACSP_PULSE_W = $clog2(ACSP_PULSE_CYC + 1);
  localparam int ACSP_TIMEOUT_CONV = 64;
  localparam int ACSP_BYTE_BITS = 8;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_POWER_UP, CMD_POWER_DOWN, CMD_RESYNC, CMD_SOFT_RESET,
    CMD_READ_ONCE, CMD_CONT_READ, CMD_STOP_CONT, CMD_REG_READ, CMD_REG_WRITE,
    CMD_SYS_OFFSET_CAL, CMD_SYS_GAIN_CAL, CMD_INT_OFFSET_CAL, CMD_IDLE_BYTE
  } acsp_cmd_type;

  typedef enum logic [1:0] {ST_CMD, ST_COUNT, ST_WRITE, ST_READ} acsp_state_type;

  function automatic acsp_cmd_type acsp_decode(input logic [7:0] b);
    acsp_cmd_type c;
    c = CMD_NONE;
    if (b[7:1] == ACSP_OP_POWER_UP) c = CMD_POWER_UP;
    else if (b[7:1] == ACSP_OP_POWER_DOWN) c = CMD_POWER_DOWN;
    else if (b[7:1] == ACSP_OP_RESYNC) c = CMD_RESYNC;
    else if (b[7:1] == ACSP_OP_SOFT_RESET) c = CMD_SOFT_RESET;
    else if (b[7:1] == ACSP_OP_READ_ONCE) c = CMD_READ_ONCE;
    else if (b[7:1] == ACSP_OP_CONT_READ) c = CMD_CONT_READ;
    else if (b[7:1] == ACSP_OP_STOP_CONT) c = CMD_STOP_CONT;
    else if (b[7:4] == ACSP_NIB_REG_READ) c = CMD_REG_READ;
    else if (b[7:4] == ACSP_NIB_REG_WRITE) c = CMD_REG_WRITE;
    else if (b == ACSP_OP_SYS_OFFSET_CAL) c = CMD_SYS_OFFSET_CAL;
    else if (b == ACSP_OP_SYS_GAIN_CAL) c = CMD_SYS_GAIN_CAL;
    else if (b == ACSP_OP_INT_OFFSET_CAL) c = CMD_INT_OFFSET_CAL;
    else if (b == ACSP_OP_IDLE_BYTE) c = CMD_IDLE_BYTE;
    return c;
  endfunction

endpackage

//--- rtl/acsp_sync.sv
// Two-stage synchroniser for a group of pin inputs.
// Assumes each bit is a slow level relative to ref_clk.
`timescale 1ns/1ps
module acsp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= INIT;
      q <= INIT;
    end else begin
      meta_r <= meta_nxt;
      q <= q_nxt;
    end
  end

endmodule

//--- rtl/acsp_port.sv
// Serial command port and result-ready signalling of a 16-bit converter.
// Assumes pins arrive unsynchronised and the converter and register file run on ref_clk.
// Overview of operation
// - Finished conversion is stored in the result buffer and ready line driven low.
// - Ready rises on first falling serial clock; otherwise pulses high before next result.
// - Shared out pin is released whenever chip select is high.
// - Select at 0: shared pin is plain data out, MSB first on rising edges.
// - Select at 1: shared pin also signals ready, except in stop continuous mode.
// - Combined mode: new result makes the pin fall, pulsing high first if low.
// - Combined mode: after a full readout the next rising serial clock drives the shared pin high.
// - Chip select high resets only the serial logic; hardware reset resets all.
// - Serial logic resets itself after 64 idle conversion cycles.
// - In power-down or start low only five commands act; read-once repeats last result.
// - Results are 16-bit two's complement, saturating at 7FFF and 8000.
// - Power-up is 0000000x, power-down 0000001x.
// - Filter resync is 0000010x, soft reset 0000011x.
// - Read-once 0001001x, continuous read 0001010x, stop continuous 0001011x.
// - Register read 0010rrrr, write 0100rrrr, then 0000nnnn count minus one.
// - Calibrations are 01100000, 01100001 and 01100010, single bytes.
// - Byte FF is idle; reserved F1 is never sent.
// - Power-up leaves power-down at the eighth falling clock unless start is low.
// - Power-down waits for the running conversion; host holds chip select low.
// - Input bits taken on falling edges, output bits launched on rising edges.
`timescale 1ns/1ps
module acsp_port
  import acsp_pkg::*;
#(
  parameter int RAW_W = 24
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Serial pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic shared_out_ready_pin,
  output logic shared_out_ready_pin_oe_n,
  output logic result_ready_n,
  // Control pins
  input wire logic start_pin,
  input wire logic ready_on_out_select,
  // Converter side
  input wire logic conv_done,
  input wire logic signed [RAW_W-1:0] conv_raw,
  output logic [15:0] result_word,
  output logic power_down,
  output logic cont_active,
  output logic resync_pulse,
  output logic soft_reset_pulse,
  output logic sys_offset_cal_pulse,
  output logic sys_gain_cal_pulse,
  output logic int_offset_cal_pulse,
  // Register file side
  output logic [3:0] reg_rd_addr,
  input wire logic [7:0] reg_rd_data,
  output logic reg_wr_en,
  output logic [3:0] reg_wr_addr,
  output logic [7:0] reg_wr_data
);

  generate
    if (RAW_W <= ACSP_RESULT_W) begin : g_bad_width
      $error("RAW_W must exceed the result width");
    end
  endgenerate

  localparam logic signed [RAW_W-1:0] RAW_POS = $signed({{(RAW_W-16){1'b0}}, ACSP_POS_FULL});
  localparam logic signed [RAW_W-1:0] RAW_NEG = $signed({{(RAW_W-16){1'b1}}, ACSP_NEG_FULL});
  localparam logic [ACSP_PULSE_W-1:0] PULSE_LOAD = ACSP_PULSE_W'(ACSP_PULSE_CYC);
  localparam logic [6:0] TIMEOUT_LAST = 7'(ACSP_TIMEOUT_CONV - 1);

  function automatic logic [15:0] sat16(input logic signed [RAW_W-1:0] v);
    if (v > RAW_POS) sat16 = ACSP_POS_FULL;
    else if (v < RAW_NEG) sat16 = ACSP_NEG_FULL;
    else sat16 = v[15:0];
  endfunction

  logic cs_s, sclk_s, din_s, start_s;
  acsp_sync #(.W(4), .INIT(4'h8)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d({cs_n, sclk, din, start_pin}),
    .q({cs_s, sclk_s, din_s, start_s})
  );

  acsp_state_type st_r, st_nxt;
  logic sclk_d_r, sclk_d_nxt;
  logic [7:0] in_sr_r, in_sr_nxt;
  logic [2:0] in_cnt_r, in_cnt_nxt;
  logic [15:0] out_sr_r, out_sr_nxt;
  logic [4:0] out_left_r, out_left_nxt;
  logic pin_r, pin_nxt;
  logic oe_n_r, oe_n_nxt;
  logic ready_n_r, ready_n_nxt;
  logic [ACSP_PULSE_W-1:0] pulse_cnt_r, pulse_cnt_nxt;
  logic [15:0] hold_r, hold_nxt;
  logic [15:0] result_r, result_nxt;
  logic cont_r, cont_nxt;
  logic cont_req_r, cont_req_nxt;
  logic pd_r, pd_nxt;
  logic pd_pend_r, pd_pend_nxt;
  logic is_write_r, is_write_nxt;
  logic [3:0] addr_r, addr_nxt;
  logic [3:0] left_r, left_nxt;
  logic rd_load_r, rd_load_nxt;
  logic [6:0] to_cnt_r, to_cnt_nxt;
  logic resync_r, resync_nxt, srst_r, srst_nxt;
  logic cal_so_r, cal_so_nxt, cal_sg_r, cal_sg_nxt, cal_io_r, cal_io_nxt;
  logic wr_en_r, wr_en_nxt;
  logic [3:0] wr_addr_r, wr_addr_nxt;
  logic [7:0] wr_data_r, wr_data_nxt;

  logic sclk_rise, sclk_fall, byte_done, low_power, combined, commit, to_hit;
  logic [7:0] byte_val;
  logic [15:0] commit_val;
  acsp_cmd_type cmd;

  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;
  assign byte_val = {in_sr_r[6:0], din_s};
  assign byte_done = sclk_fall & ~cs_s & (in_cnt_r == 3'h7);
  assign cmd = acsp_decode(byte_val);
  assign low_power = pd_r | ~start_s;
  assign combined = ready_on_out_select & cont_r;
  assign to_hit = conv_done & ~cs_s & ~sclk_rise & ~sclk_fall & (to_cnt_r == TIMEOUT_LAST);

  always_comb begin
    st_nxt = st_r;
    sclk_d_nxt = sclk_s;
    in_sr_nxt = in_sr_r;
    in_cnt_nxt = in_cnt_r;
    out_sr_nxt = out_sr_r;
    out_left_nxt = out_left_r;
    pin_nxt = pin_r;
    oe_n_nxt = cs_s;
    ready_n_nxt = ready_n_r;
    pulse_cnt_nxt = pulse_cnt_r;
    hold_nxt = hold_r;
    result_nxt = result_r;
    cont_nxt = cont_r;
    cont_req_nxt = cont_req_r;
    pd_nxt = pd_r;
    pd_pend_nxt = pd_pend_r;
    is_write_nxt = is_write_r;
    addr_nxt = addr_r;
    left_nxt = left_r;
    rd_load_nxt = 1'b0;
    to_cnt_nxt = to_cnt_r;
    resync_nxt = 1'b0;
    srst_nxt = 1'b0;
    cal_so_nxt = 1'b0;
    cal_sg_nxt = 1'b0;
    cal_io_nxt = 1'b0;
    wr_en_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    wr_data_nxt = wr_data_r;
    commit = 1'b0;
    commit_val = hold_r;

    // Launch on rising edge; after the last bit the combined pin returns high
    if (sclk_rise && !cs_s) begin
      if (out_left_r != 5'h00) begin
        pin_nxt = out_sr_r[15];
        out_sr_nxt = {out_sr_r[14:0], 1'b0};
        out_left_nxt = out_left_r - 5'h01;
      end else if (combined) begin
        pin_nxt = 1'b1;
      end
    end

    if (rd_load_r) begin
      out_sr_nxt = {reg_rd_data, 8'h00};
      out_left_nxt = 5'h08;
    end

    // Capture on falling edge
    if (sclk_fall && !cs_s) begin
      in_sr_nxt = byte_val;
      in_cnt_nxt = in_cnt_r + 3'h1;
    end

    if (byte_done) begin
      unique case (st_r)
        ST_CMD: begin
          // Restricted and unknown bytes fall through to no action
          if (!low_power || cmd inside {CMD_POWER_UP, CMD_READ_ONCE, CMD_CONT_READ,
                                        CMD_STOP_CONT, CMD_IDLE_BYTE}) begin
            unique case (cmd)
              CMD_POWER_UP: begin
                if (start_s) begin
                  pd_nxt = 1'b0;
                  pd_pend_nxt = 1'b0;
                end
              end
              CMD_POWER_DOWN: pd_pend_nxt = 1'b1;
              CMD_RESYNC: resync_nxt = 1'b1;
              CMD_SOFT_RESET: begin
                srst_nxt = 1'b1;
                cont_nxt = 1'b1;
                cont_req_nxt = 1'b1;
              end
              CMD_READ_ONCE: begin
                out_sr_nxt = result_r;
                out_left_nxt = 5'h10;
              end
              CMD_CONT_READ: cont_req_nxt = 1'b1;
              CMD_STOP_CONT: cont_req_nxt = 1'b0;
              CMD_REG_READ, CMD_REG_WRITE: begin
                is_write_nxt = (cmd == CMD_REG_WRITE);
                addr_nxt = byte_val[3:0];
                st_nxt = ST_COUNT;
              end
              CMD_SYS_OFFSET_CAL: cal_so_nxt = 1'b1;
              CMD_SYS_GAIN_CAL: cal_sg_nxt = 1'b1;
              CMD_INT_OFFSET_CAL: cal_io_nxt = 1'b1;
              CMD_IDLE_BYTE, CMD_NONE: ;
            endcase
          end
        end
        ST_COUNT: begin
          left_nxt = byte_val[3:0];
          st_nxt = is_write_r ? ST_WRITE : ST_READ;
          rd_load_nxt = ~is_write_r;
        end
        ST_WRITE: begin
          wr_en_nxt = 1'b1;
          wr_addr_nxt = addr_r;
          wr_data_nxt = byte_val;
          addr_nxt = addr_r + 4'h1;
          left_nxt = left_r - 4'h1;
          if (left_r == 4'h0) st_nxt = ST_CMD;
        end
        ST_READ: begin
          // Bytes arriving during readout are ignored
          if (left_r == 4'h0) begin
            st_nxt = ST_CMD;
          end else begin
            left_nxt = left_r - 4'h1;
            addr_nxt = addr_r + 4'h1;
            rd_load_nxt = 1'b1;
          end
        end
      endcase
    end

    // Ready is forced high by serial clock whatever chip select does
    if (sclk_fall && pulse_cnt_r == '0) ready_n_nxt = 1'b1;

    if (conv_done) begin
      hold_nxt = sat16(conv_raw);
      if (pd_pend_r) begin
        pd_nxt = 1'b1;
        pd_pend_nxt = 1'b0;
      end
    end

    // Pulse keeps counting through later conversions, so its width never stretches
    if (pulse_cnt_r != '0) begin
      pulse_cnt_nxt = pulse_cnt_r - ACSP_PULSE_W'(1);
      if (pulse_cnt_r == ACSP_PULSE_W'(1)) begin
        commit = 1'b1;
        commit_val = hold_nxt;
      end
    end else if (conv_done) begin
      if (!ready_n_r || (combined && !pin_r)) begin
        pulse_cnt_nxt = PULSE_LOAD;
        ready_n_nxt = 1'b1;
        if (combined) pin_nxt = 1'b1;
      end else begin
        commit = 1'b1;
        commit_val = hold_nxt;
      end
    end

    if (commit) begin
      result_nxt = commit_val;
      ready_n_nxt = 1'b0;
      cont_nxt = cont_req_r;
      if (cont_r) begin
        out_sr_nxt = commit_val;
        out_left_nxt = 5'h10;
      end
      if (combined) pin_nxt = 1'b0;
    end

    // Idle timeout counted in conversion cycles
    if (cs_s || sclk_rise || sclk_fall) to_cnt_nxt = 7'h00;
    else if (conv_done) to_cnt_nxt = to_hit ? 7'h00 : to_cnt_r + 7'h01;

    // Serial-only reset; registers, filter and conversion state untouched
    if (cs_s || to_hit) begin
      st_nxt = ST_CMD;
      in_cnt_nxt = 3'h0;
      out_left_nxt = 5'h00;
      rd_load_nxt = 1'b0;
      wr_en_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_CMD;
      sclk_d_r <= 1'b0;
      in_sr_r <= 8'h00;
      in_cnt_r <= 3'h0;
      out_sr_r <= 16'h0000;
      out_left_r <= 5'h00;
      pin_r <= 1'b1;
      oe_n_r <= 1'b1;
      ready_n_r <= 1'b1;
      pulse_cnt_r <= '0;
      hold_r <= 16'h0000;
      result_r <= 16'h0000;
      cont_r <= 1'b1;
      cont_req_r <= 1'b1;
      pd_r <= 1'b0;
      pd_pend_r <= 1'b0;
      is_write_r <= 1'b0;
      addr_r <= 4'h0;
      left_r <= 4'h0;
      rd_load_r <= 1'b0;
      to_cnt_r <= 7'h00;
      resync_r <= 1'b0;
      srst_r <= 1'b0;
      cal_so_r <= 1'b0;
      cal_sg_r <= 1'b0;
      cal_io_r <= 1'b0;
      wr_en_r <= 1'b0;
      wr_addr_r <= 4'h0;
      wr_data_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      sclk_d_r <= sclk_d_nxt;
      in_sr_r <= in_sr_nxt;
      in_cnt_r <= in_cnt_nxt;
      out_sr_r <= out_sr_nxt;
      out_left_r <= out_left_nxt;
      pin_r <= pin_nxt;
      oe_n_r <= oe_n_nxt;
      ready_n_r <= ready_n_nxt;
      pulse_cnt_r <= pulse_cnt_nxt;
      hold_r <= hold_nxt;
      result_r <= result_nxt;
      cont_r <= cont_nxt;
      cont_req_r <= cont_req_nxt;
      pd_r <= pd_nxt;
      pd_pend_r <= pd_pend_nxt;
      is_write_r <= is_write_nxt;
      addr_r <= addr_nxt;
      left_r <= left_nxt;
      rd_load_r <= rd_load_nxt;
      to_cnt_r <= to_cnt_nxt;
      resync_r <= resync_nxt;
      srst_r <= srst_nxt;
      cal_so_r <= cal_so_nxt;
      cal_sg_r <= cal_sg_nxt;
      cal_io_r <= cal_io_nxt;
      wr_en_r <= wr_en_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_data_r <= wr_data_nxt;
    end
  end

  assign shared_out_ready_pin = pin_r;
  assign shared_out_ready_pin_oe_n = oe_n_r;
  assign result_ready_n = ready_n_r;
  assign result_word = result_r;
  assign power_down = pd_r;
  assign cont_active = cont_r;
  assign resync_pulse = resync_r;
  assign soft_reset_pulse = srst_r;
  assign sys_offset_cal_pulse = cal_so_r;
  assign sys_gain_cal_pulse = cal_sg_r;
  assign int_offset_cal_pulse = cal_io_r;
  assign reg_rd_addr = addr_r;
  assign reg_wr_en = wr_en_r;
  assign reg_wr_addr = wr_addr_r;
  assign reg_wr_data = wr_data_r;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_pin_release: assert property (cs_s |=> oe_n_r) else $error("shared pin driven with cs high");
  chk_ready_sclk_high: assert property (sclk_fall && !conv_done && pulse_cnt_r == '0
    |=> ready_n_r) else $error("ready not raised by serial clock");
  chk_ready_pulse_len: assert property (conv_done && pulse_cnt_r == '0 && !ready_n_r
    |=> ready_n_r [*4] ##1 !ready_n_r) else $error("ready pulse width wrong");
  chk_result_commit: assert property (conv_done && pulse_cnt_r == '0 && ready_n_r && !(combined && !pin_r)
    |=> !ready_n_r && result_r == hold_r) else $error("result not committed");
  chk_shift_msb: assert property (sclk_rise && !cs_s && out_left_r != 5'h00 && !rd_load_r && !commit
    |=> pin_r == $past(out_sr_r[15])) else $error("wrong data bit launched");
  chk_done_high: assert property (sclk_rise && !cs_s && out_left_r == 5'h00 && combined && !conv_done
    && pulse_cnt_r == '0 |=> pin_r) else $error("pin not high after readout");
  chk_wake_edge: assert property (byte_done && st_r == ST_CMD && cmd == CMD_POWER_UP && start_s && !conv_done
    |=> !pd_r) else $error("power-up not taken");
  chk_wake_start_low: assert property (byte_done && cmd == CMD_POWER_UP && !start_s && pd_r
    |=> pd_r) else $error("power-up taken with start low");
  chk_sleep_waits: assert property ($rose(pd_r) |-> $past(conv_done)) else $error("power-down before conversion end");
  chk_saturate_pos: assert property (conv_done && conv_raw > RAW_POS
    |=> hold_r == ACSP_POS_FULL) else $error("positive clip wrong");
  chk_low_power_block: assert property (byte_done && st_r == ST_CMD && low_power && cmd == CMD_RESYNC
    |=> !resync_pulse) else $error("command acted in power-down");
  chk_timeout_reset: assert property (to_hit |=> st_r == ST_CMD && in_cnt_r == 3'h0 && out_left_r == 5'h00)
    else $error("timeout did not reset serial logic");

  cov_cont_result: cover property (commit && cont_r ##[1:1000] out_left_r == 5'h00);
  cov_reg_read: cover property (st_r == ST_READ ##[1:1000] st_r == ST_CMD);
  cov_combined_pulse: cover property (conv_done && combined && !pin_r ##1 pulse_cnt_r != '0);
  cov_sleep_wake: cover property ($rose(pd_r) ##[1:1000] $fell(pd_r));

endmodule

//--- tb/acsp_host.sv
// Serial host model: drives select, serial clock and command bits.
// Assumes ref_clk at 50 ns; the serial clock runs at 400 ns only within frames.
`timescale 1ns/1ps
module acsp_host (
  // Clock
  input wire logic ref_clk,
  // Serial pins
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout_pin
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b1;
  end

  task automatic half();
    repeat (4) @(posedge ref_clk);
    #5;
  endtask

  // Select stays put for a whole exchange
  task automatic select(input logic lvl);
    @(posedge ref_clk);
    #5;
    cs_n = lvl;
    half();
  endtask

  // Bit launched with the rise, sampled just before the next rise
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < nbits; i++) begin
      din = tx[7 - i];
      sclk = 1'b1;
      half();
      sclk = 1'b0;
      half();
      rx = {rx[6:0], dout_pin};
    end
    // Released data line must not look like the last bit
    din = ~din;
  endtask
endmodule

//--- tb/tb.sv
// Self-checking bench for the serial command and ready port.
// Assumes the host model owns the serial pins; the bench plays converter and register file.
`timescale 1ns/1ps
module tb;
  import acsp_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic start_pin = 1'b1;
  logic sel = 1'b0;
  logic conv_done = 1'b0;
  logic signed [23:0] conv_raw = 24'h000000;
  logic cs_n, sclk, din, pin, oe_n, ready_n, pin_level, power_down, cont_active, wr_en;
  logic [15:0] result_word;
  logic [15:0] v;
  logic [4:0] pulses;
  logic [3:0] rd_addr, wr_addr;
  logic [7:0] wr_data, rx;
  logic [11:0] wq [$];
  int pcnt [5];
  int err_total = 0;
  int checks_done = 0;
  logic signed [23:0] raws [4] = '{24'h012345, 24'hFF8000, 24'hF00000, 24'hFFFFFB};
  logic [15:0] exps [4] = '{ACSP_POS_FULL, ACSP_NEG_FULL, ACSP_NEG_FULL, 16'hFFFB};
  logic [7:0] ops [8] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h60, 8'h61, 8'h62, 8'h30};

  always #25 ref_clk = ~ref_clk;
  // Pull-up on the shared pin when released
  assign pin_level = oe_n ? 1'b1 : pin;

  acsp_host i_acsp_host (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout_pin(pin_level));

  acsp_port i_acsp_port (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .din(din),
    .shared_out_ready_pin(pin), .shared_out_ready_pin_oe_n(oe_n), .result_ready_n(ready_n),
    .start_pin(start_pin), .ready_on_out_select(sel), .conv_done(conv_done), .conv_raw(conv_raw),
    .result_word(result_word), .power_down(power_down), .cont_active(cont_active),
    .resync_pulse(pulses[0]), .soft_reset_pulse(pulses[1]), .sys_offset_cal_pulse(pulses[2]),
    .sys_gain_cal_pulse(pulses[3]), .int_offset_cal_pulse(pulses[4]), .reg_rd_addr(rd_addr),
    .reg_rd_data({4'hC, rd_addr}), .reg_wr_en(wr_en), .reg_wr_addr(wr_addr), .reg_wr_data(wr_data));

  always @(posedge ref_clk) begin
    for (int k = 0; k < 5; k++) begin
      if (pulses[k] === 1'b1) pcnt[k]++;
    end
    if (wr_en === 1'b1) wq.push_back({wr_addr, wr_data});
  end

  task automatic final_report();
    if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask

  task automatic conv(input logic signed [23:0] raw);
    conv_raw = raw;
    conv_done = 1'b1;
    cyc(1);
    conv_done = 1'b0;
    cyc(1);
  endtask

  task automatic send(input logic [7:0] b);
    i_acsp_host.xfer(b, 8, rx);
    cyc(4);
  endtask

  task automatic rd16(output logic [15:0] w);
    send(ACSP_OP_IDLE_BYTE);
    w[15:8] = rx;
    send(ACSP_OP_IDLE_BYTE);
    w[7:0] = rx;
  endtask

  initial begin
    cyc(10);
    cmp_bit("ready_n reset", 1'b1, ready_n);
    cmp_bit("oe_n reset", 1'b1, oe_n);
    cmp_bit("cont reset", 1'b1, cont_active);
    rst_n = 1'b1;
    cyc(4);
    i_acsp_host.select(1'b0);
    cmp_bit("oe_n selected", 1'b0, oe_n);
    for (int i = 0; i < 4; i++) begin
      conv(raws[i]);
      cmp_bit("ready_n fall", 1'b0, ready_n);
      cmp_val("result buffer", exps[i], result_word);
      cyc(4);
      rd16(v);
      cmp_val("cont data", exps[i], v);
      cmp_bit("ready_n raised", 1'b1, ready_n);
    end
    foreach (ops[i]) send(ops[i]);
    cmp_val("resync", 16'd2, 16'(pcnt[0]));
    cmp_val("soft reset", 16'd2, 16'(pcnt[1]));
    cmp_val("offset cal", 16'd1, 16'(pcnt[2]));
    cmp_val("gain cal", 16'd1, 16'(pcnt[3]));
    cmp_val("int cal", 16'd1, 16'(pcnt[4]));
    cmp_val("unknown byte", 16'd0, 16'(wq.size()));
    send(8'h43);
    send(8'h01);
    send(8'hA5);
    send(8'h5A);
    cmp_val("writes", 16'd2, 16'(wq.size()));
    cmp_val("write 0", 16'h03A5, {4'h0, wq[0]});
    cmp_val("write 1", 16'h045A, {4'h0, wq[1]});
    send(8'h2F);
    send(8'h01);
    rd16(v);
    cmp_val("reg read wrap", 16'hCFC0, v);
    send(8'h16);
    conv(24'h000123);
    cmp_bit("stop cont", 1'b0, cont_active);
    send(8'h02);
    cmp_bit("pd waits conv", 1'b0, power_down);
    conv(24'h000456);
    cmp_bit("pd entered", 1'b1, power_down);
    send(8'h04);
    cmp_val("pd refuses", 16'd2, 16'(pcnt[0]));
    repeat (2) begin
      send(8'h12);
      rd16(v);
      cmp_val("read once", 16'h0456, v);
    end
    start_pin = 1'b0;
    cyc(3);
    send(8'h00);
    cmp_bit("wake start low", 1'b1, power_down);
    start_pin = 1'b1;
    cyc(3);
    send(8'h00);
    cmp_bit("power up", 1'b0, power_down);
    start_pin = 1'b0;
    cyc(3);
    send(8'h05);
    cmp_val("start low refuses", 16'd2, 16'(pcnt[0]));
    start_pin = 1'b1;
    cyc(3);
    i_acsp_host.xfer(8'h00, 4, rx);
    repeat (64) conv(24'h000001);
    send(8'h04);
    cmp_val("idle timeout", 16'd3, 16'(pcnt[0]));
    i_acsp_host.xfer(8'h00, 3, rx);
    i_acsp_host.select(1'b1);
    i_acsp_host.select(1'b0);
    send(8'h05);
    cmp_val("cs serial reset", 16'd4, 16'(pcnt[0]));
    cmp_val("cs keeps result", 16'h0001, result_word);
    send(8'h14);
    conv(24'h0055AA);
    cmp_bit("cont again", 1'b1, cont_active);
    cyc(4);
    rd16(v);
    sel = 1'b1;
    send(ACSP_OP_IDLE_BYTE);
    cmp_val("pin forced high", 16'h00FF, {8'h00, rx});
    conv(24'h001234);
    cmp_bit("combined fall", 1'b0, pin_level);
    cyc(4);
    rd16(v);
    cmp_val("combined data", 16'h1234, v);
    conv(24'h000321);
    cmp_bit("combined pulse", 1'b1, pin_level);
    cyc(5);
    cmp_bit("combined refall", 1'b0, pin_level);
    i_acsp_host.select(1'b1);
    cmp_bit("oe_n released", 1'b1, oe_n);
    final_report();
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    err_total++;
    final_report();
  end
endmodule
